// File: rtl/cpu_general_register_file.v
// Core general register file with execution ports and APB access
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "cpu_regfile_regs.vh"

module cpu_general_register_file (
  input  wire        core_clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Execution write port
  input  wire        ex_wr_en,
  input  wire [3:0]  ex_wr_sel,
  input  wire [1:0]  ex_wr_size,
  input  wire [31:0] ex_wr_data,
  // Execution read ports
  input  wire [3:0]  ex_rd_sel_a,
  input  wire [1:0]  ex_rd_size_a,
  input  wire [3:0]  ex_rd_sel_b,
  output reg  [31:0] ex_rd_data_a,
  output reg  [31:0] ex_rd_data_b,
  // Program counter update
  input  wire        pc_load,
  input  wire [23:0] pc_next,
  // Address generation bases, program counter and flag word
  output reg  [23:0] stack_pointer,
  output reg  [23:0] static_base_out,
  output reg  [23:0] frame_base_out,
  output reg  [23:0] vector_base_out,
  output reg  [23:0] program_counter_out,
  output reg  [15:0] flag_word_out
);

  // ===================================================================
  // Shared state
  reg  [23:0] program_counter;
  reg  [15:0] cpu_flag_word;
  wire        bank_sel  = cpu_flag_word[`FLG_BANK_BIT];
  wire        stack_sel = cpu_flag_word[`FLG_STACK_BIT];

  // ===================================================================
  // APB decode: writes land on the access phase edge only
  wire apb_access = psel && penable;

  // ===================================================================
  // Bus answer sequencer: one answer per access, so a write lands once
  // Waiting for the first access edge
  localparam [1:0] ST_IDLE   = 2'b01;
  // Answer standing for one cycle
  localparam [1:0] ST_ANSWER = 2'b10;
  reg  [1:0]  bus_state_reg;
  reg  [1:0]  bus_state_next;

  always @* begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      ST_IDLE: begin
        if (apb_access) begin
          bus_state_next = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        bus_state_next = ST_IDLE;
      end
      // Unknown codes fall back to idle
      default: begin
        bus_state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      bus_state_reg <= ST_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // Held access edge with pready up must not write a second time
  wire apb_take   = apb_access && (bus_state_reg == ST_IDLE);
  wire apb_wr     = apb_take && pwrite;
  reg  [3:0]  apb_sel;
  reg         apb_hit;

  always @* begin
    apb_hit = 1'b1;
    apb_sel = `SEL_D0;
    case (paddr)
      `OFS_DATA_REG_0:      apb_sel = `SEL_D0;
      `OFS_DATA_REG_1:      apb_sel = `SEL_D1;
      `OFS_DATA_REG_2:      apb_sel = `SEL_D2;
      `OFS_DATA_REG_3:      apb_sel = `SEL_D3;
      `OFS_ADDR_INDEX_0:    apb_sel = `SEL_A0;
      `OFS_ADDR_INDEX_1:    apb_sel = `SEL_A1;
      `OFS_STATIC_BASE:     apb_sel = `SEL_SB;
      `OFS_FRAME_BASE:      apb_sel = `SEL_FB;
      `OFS_USER_STACK:      apb_sel = `SEL_USP;
      `OFS_INTR_STACK:      apb_sel = `SEL_ISP;
      `OFS_VECTOR_BASE:     apb_sel = `SEL_VTB;
      `OFS_PROGRAM_COUNTER: apb_sel = `SEL_PC;
      `OFS_FLAG_WORD:       apb_sel = `SEL_FLAG;
      `OFS_ACTIVE_STACK:    apb_sel = `SEL_SPACT;
      default:              apb_hit = 1'b0;
    endcase
  end

  // Program counter is read only from the bus
  wire apb_wr_ok = apb_wr && apb_hit && (apb_sel != `SEL_PC);

  // ===================================================================
  // Write arbitration
  // One write per cycle, execution first
  wire        wr_go   = ex_wr_en || apb_wr_ok;
  wire [3:0]  wr_sel  = ex_wr_en ? ex_wr_sel : apb_sel;
  wire [1:0]  wr_size = ex_wr_en ? ex_wr_size : `SZ_WORD;
  wire [31:0] wr_data = ex_wr_en ? ex_wr_data : pwdata;
  // Bus loses a write clashing with the core; it gets an error answer
  wire        apb_lost = apb_wr && apb_hit && ex_wr_en;

  // ===================================================================
  // Two data banks
  wire [63:0] bank_flat [0:1];
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bank
      wire bank_wr = wr_go && (wr_sel[3:2] == 2'b00) && (bank_sel == b);
      data_reg_bank u_bank (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .wr_en     (bank_wr),
        .wr_idx    (wr_sel[1:0]),
        .wr_size   (wr_size),
        .wr_data   (wr_data),
        .data_flat (bank_flat[b])
      );
    end
  endgenerate

  // Bus and core see the current bank only; the other bank keeps its values
  wire [63:0] data_flat = bank_sel ? bank_flat[1] : bank_flat[0];

  // ===================================================================
  // Pointer registers
  // Active-stack writes steer to the flagged pointer
  wire [3:0]  ptr_sel   = (wr_sel == `SEL_SPACT) ?
                          (stack_sel ? `SEL_ISP : `SEL_USP) : wr_sel;
  // Flag and counter selectors lie outside this range and never land here
  wire        ptr_wr    = wr_go && (ptr_sel >= `SEL_A0) && (ptr_sel <= `SEL_VTB);
  wire [3:0]  ptr_ofs   = ptr_sel - `SEL_A0;
  wire [167:0] ptr_flat;

  address_reg_set u_ptrs (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (ptr_wr),
    .wr_idx   (ptr_ofs[2:0]),
    .wr_data  (wr_data[23:0]),
    .ptr_flat (ptr_flat)
  );

  wire [23:0] addr_idx0 = ptr_flat[23:0];
  wire [23:0] addr_idx1 = ptr_flat[47:24];
  wire [23:0] sb_val    = ptr_flat[71:48];
  wire [23:0] fb_val    = ptr_flat[95:72];
  wire [23:0] usp_val   = ptr_flat[119:96];
  wire [23:0] isp_val   = ptr_flat[143:120];
  wire [23:0] vtb_val   = ptr_flat[167:144];
  wire [23:0] sp_val    = stack_sel ? isp_val : usp_val;

  // ===================================================================
  // Flag word and program counter
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cpu_flag_word <= `RST_FLAG16;
    end else if (wr_go && wr_sel == `SEL_FLAG) begin
      cpu_flag_word <= wr_data[15:0];
    end
  end

  // Only the core loads the counter; bus writes to it are ignored
  always @(posedge core_clk) begin
    if (!rst_n) begin
      program_counter <= `RST_ADDR24;
    end else if (pc_load) begin
      program_counter <= pc_next;
    end
  end

  // ===================================================================
  // Read mux, shared by core ports and bus
  // Byte sizes on registers 2 and 3 read back as a whole word
  function [31:0] read_sel;
    input [3:0] sel;
    input [1:0] size;
    begin
      read_sel = 32'h0000_0000;
      case (sel)
        `SEL_D0, `SEL_D1, `SEL_D2, `SEL_D3: begin
          // Byte halves of first two registers
          if (size == `SZ_LOW && sel[1] == 1'b0) begin
            read_sel = {24'h00_0000, data_flat[sel[0]*16 +: 8]};
          end else if (size == `SZ_HIGH && sel[1] == 1'b0) begin
            read_sel = {24'h00_0000, data_flat[sel[0]*16 + 8 +: 8]};
          end else if (size == `SZ_LONG) begin
            // Pair read, upper word from 2 or 3
            read_sel = {data_flat[(sel[0]+2)*16 +: 16], data_flat[sel[0]*16 +: 16]};
          end else begin
            read_sel = {16'h0000, data_flat[sel[1:0]*16 +: 16]};
          end
        end
        `SEL_A0:    read_sel = {8'h00, addr_idx0};
        `SEL_A1:    read_sel = {8'h00, addr_idx1};
        `SEL_SB:    read_sel = {8'h00, sb_val};
        `SEL_FB:    read_sel = {8'h00, fb_val};
        `SEL_USP:   read_sel = {8'h00, usp_val};
        `SEL_ISP:   read_sel = {8'h00, isp_val};
        `SEL_VTB:   read_sel = {8'h00, vtb_val};
        `SEL_SPACT: read_sel = {8'h00, sp_val};
        `SEL_FLAG:  read_sel = {16'h0000, cpu_flag_word};
        `SEL_PC:    read_sel = {8'h00, program_counter};
        default:    read_sel = 32'h0000_0000;
      endcase
    end
  endfunction

  // ===================================================================
  // Registered outputs
  // Reads have no side effects
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ex_rd_data_a        <= 32'h0000_0000;
      ex_rd_data_b        <= 32'h0000_0000;
      stack_pointer       <= `RST_ADDR24;
      static_base_out     <= `RST_ADDR24;
      frame_base_out      <= `RST_ADDR24;
      vector_base_out     <= `RST_ADDR24;
      program_counter_out <= `RST_ADDR24;
      flag_word_out       <= `RST_FLAG16;
    end else begin
      ex_rd_data_a        <= read_sel(ex_rd_sel_a, ex_rd_size_a);
      ex_rd_data_b        <= read_sel(ex_rd_sel_b, `SZ_WORD);
      stack_pointer       <= sp_val;
      static_base_out     <= sb_val;
      frame_base_out      <= fb_val;
      vector_base_out     <= vtb_val;
      program_counter_out <= program_counter;
      flag_word_out       <= cpu_flag_word;
    end
  end

  // ===================================================================
  // Bus answer values, taken on the first access edge
  // Writes answer zero so stale read data never leaks into a write reply
  wire        apb_err_next   = !apb_hit || apb_lost;
  wire [31:0] apb_rdata_next = (apb_hit && !pwrite) ? read_sel(apb_sel, `SZ_WORD) :
                                                      32'h0000_0000;

  // Answer one cycle into the access phase, so pready is a clean flop
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (apb_take) begin
      pready  <= 1'b1;
      pslverr <= apb_err_next;
      prdata  <= apb_rdata_next;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// File: rtl/cpu_regfile_regs.vh
// Register offsets, field positions, reset values and widths of the core register file
`ifndef CPU_REGFILE_REGS_VH
`define CPU_REGFILE_REGS_VH

// =====================================================================
// Register offsets (byte addresses on the APB)
`define OFS_DATA_REG_0      12'h000
`define OFS_DATA_REG_1      12'h004
`define OFS_DATA_REG_2      12'h008
`define OFS_DATA_REG_3      12'h00C
`define OFS_ADDR_INDEX_0    12'h010
`define OFS_ADDR_INDEX_1    12'h014
`define OFS_STATIC_BASE     12'h018
`define OFS_FRAME_BASE      12'h01C
`define OFS_USER_STACK      12'h020
`define OFS_INTR_STACK      12'h024
`define OFS_VECTOR_BASE     12'h028
`define OFS_PROGRAM_COUNTER 12'h02C
`define OFS_FLAG_WORD       12'h030
`define OFS_ACTIVE_STACK    12'h034

// =====================================================================
// Flag word fields
`define FLG_BANK_BIT        4
`define FLG_STACK_BIT       7

// =====================================================================
// Reset values
`define RST_DATA16          16'h0000
`define RST_ADDR24          24'h00_0000
`define RST_FLAG16          16'h0000

// =====================================================================
// Execution-side register selectors
`define SEL_D0              4'h0
`define SEL_D1              4'h1
`define SEL_D2              4'h2
`define SEL_D3              4'h3
`define SEL_A0              4'h4
`define SEL_A1              4'h5
`define SEL_SB              4'h6
`define SEL_FB              4'h7
`define SEL_USP             4'h8
`define SEL_ISP             4'h9
`define SEL_VTB             4'hA
`define SEL_SPACT           4'hB
`define SEL_FLAG            4'hC
`define SEL_PC              4'hD

// Write size codes
`define SZ_LOW              2'h0
`define SZ_HIGH             2'h1
`define SZ_WORD             2'h2
`define SZ_LONG             2'h3

`endif

// File: rtl/data_reg_bank.v
// One bank of the four data registers, the first two split into bytes, with pairing
`timescale 1ns/10ps
`include "cpu_regfile_regs.vh"

module data_reg_bank (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire [1:0]  wr_idx,
  input  wire [1:0]  wr_size,
  input  wire [31:0] wr_data,
  output wire [63:0] data_flat
);

  reg  [15:0] data_reg [0:3];
  wire [15:0] pair_hi_next [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_reg
      // Pairs take upper word for members 2 and 3
      assign pair_hi_next[g] = (g >= 2) ? wr_data[31:16] : wr_data[15:0];
      always @(posedge core_clk) begin
        if (!rst_n) begin
          data_reg[g] <= `RST_DATA16;
        end else if (wr_en) begin
          if (wr_size == `SZ_LOW && wr_idx == g && g < 2) begin
            data_reg[g][7:0] <= wr_data[7:0];
          end else if (wr_size == `SZ_HIGH && wr_idx == g && g < 2) begin
            data_reg[g][15:8] <= wr_data[7:0];
          end else if (wr_size == `SZ_WORD && wr_idx == g) begin
            data_reg[g] <= wr_data[15:0];
          // Pair 0 is 2:0, pair 1 is 3:1
          end else if (wr_size == `SZ_LONG && wr_idx[0] == (g % 2)) begin
            data_reg[g] <= pair_hi_next[g];
          end
        end
      end
      assign data_flat[g*16 +: 16] = data_reg[g];
    end
  endgenerate

endmodule

// File: rtl/address_reg_set.v
// Pointer registers: address, base, stack and vector table
`timescale 1ns/10ps
`include "cpu_regfile_regs.vh"

module address_reg_set (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire [2:0]  wr_idx,
  input  wire [23:0] wr_data,
  output wire [167:0] ptr_flat
);

  // Order: idx0, idx1, static, frame, user sp, intr sp, vector base
  reg [23:0] ptr_reg [0:6];

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_ptr
      always @(posedge core_clk) begin
        if (!rst_n) begin
          ptr_reg[g] <= `RST_ADDR24;
        end else if (wr_en && wr_idx == g) begin
          ptr_reg[g] <= wr_data;
        end
      end
      assign ptr_flat[g*24 +: 24] = ptr_reg[g];
    end
  endgenerate

endmodule

// File: verification/core_exec_model.sv
// Model of the execution side that steps the program counter
`timescale 1ns/10ps

module core_exec_model (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        run,
  output reg         pc_load,
  output reg  [23:0] pc_next,
  output reg  [23:0] pc_model
);
  // ==========================================
  // Fetch stepping
  // Next fetch address
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pc_load  <= 1'h0;
      pc_next  <= 24'h00_0000;
      pc_model <= 24'h00_0000;
    end else if (run) begin
      pc_load  <= 1'h1;
      pc_next  <= pc_model + 24'h00_0002;
      pc_model <= pc_model + 24'h00_0002;
    end else begin
      pc_load <= 1'h0;
      // Idle bus toggles so a stray load cannot go unseen
      pc_next <= ~pc_next;
    end
  end
endmodule

// File: verification/regfile_checker_sva.sv
// Port assertions for the core register file
`timescale 1ns/10ps

module regfile_checker (
  input wire        core_clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        ex_wr_en,
  input wire        pc_load,
  input wire [23:0] pc_next,
  input wire [23:0] stack_pointer,
  input wire [23:0] program_counter_out,
  input wire [15:0] flag_word_out
);
  // ==========================================
  // Helpers
  wire access_w = psel && penable && !pready;
  wire quiet    = !ex_wr_en && !(psel && penable && pwrite);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================
  // Assertions
  AST_READY_AFTER_ACCESS: assert property (access_w |=> pready)
    else $error("ready missing after access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED: assert property (access_w && !pwrite && paddr > 12'h034
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_CORE_WINS: assert property (access_w && pwrite && ex_wr_en |=> pslverr)
    else $error("clashing bus write not refused");
  AST_PC_LOAD: assert property (pc_load |-> ##2 program_counter_out == $past(pc_next, 2))
    else $error("program counter load wrong");
  AST_PC_HOLD: assert property (!pc_load |-> ##2 $stable(program_counter_out))
    else $error("program counter moved without load");
  AST_FLAG_HOLD: assert property (quiet |-> ##2 $stable(flag_word_out))
    else $error("flag word moved without write");
  AST_STACK_HOLD: assert property (quiet |-> ##2 $stable(stack_pointer))
    else $error("active stack moved without write");
endmodule

bind cpu_general_register_file regfile_checker regfile_checker_i (
  .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .ex_wr_en, .pc_load, .pc_next, .stack_pointer, .program_counter_out, .flag_word_out
);

// File: verification/cpu_general_register_file_test.sv
// Self-checking bench for the core register file
`timescale 1ns/10ps
`include "cpu_regfile_regs.vh"

module cpu_general_register_file_test;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
    logic        er;
  } row_t;
  reg          core_clk = 1'h0, rst_n = 1'h0, run = 1'h0;
  reg          psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ex_wr_en = 1'h0;
  reg   [11:0] paddr = 12'h000;
  reg   [31:0] pwdata = 32'h0000_0000, ex_wr_data = 32'h0000_0000;
  reg   [3:0]  ex_wr_sel = 4'h0, ex_rd_sel_a = 4'h0, ex_rd_sel_b = 4'h0;
  reg   [1:0]  ex_wr_size = 2'h0, ex_rd_size_a = 2'h0;
  wire  [31:0] prdata, ex_rd_data_a, ex_rd_data_b;
  wire         pready, pslverr, pc_load;
  wire  [23:0] pc_next, pc_model, stack_pointer, static_base_out, frame_base_out;
  wire  [23:0] vector_base_out, program_counter_out;
  wire  [15:0] flag_word_out;
  reg   [31:0] rd;
  reg          er;
  integer      num_errors = 0, checks = 0, i;
  row_t        rows [0:12];

  always #20 core_clk = ~core_clk;

  cpu_general_register_file cpu_general_register_file_i (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ex_wr_en, .ex_wr_sel, .ex_wr_size, .ex_wr_data, .ex_rd_sel_a,
    .ex_rd_size_a, .ex_rd_sel_b, .ex_rd_data_a, .ex_rd_data_b, .pc_load, .pc_next,
    .stack_pointer, .static_base_out, .frame_base_out, .vector_base_out,
    .program_counter_out, .flag_word_out);
  core_exec_model core_exec_model_i (.core_clk, .rst_n, .run, .pc_load, .pc_next, .pc_model);

  // ==========================================
  // Tasks
  task end_sim;
    begin
      if (num_errors == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bus cycle; a clash raises the core strobe on the access edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd, input logic clash);
    integer n;
    begin
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'h1;
      ex_wr_en <= clash;
      n = 0;
      do begin
        @(posedge core_clk);
        ex_wr_en <= 1'h0;
        n = n + 1;
      end while (pready !== 1'h1 && n < 16);
      if (pready !== 1'h1) begin
        num_errors = num_errors + 1;
        end_sim;
      end else begin
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
      end
    end
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    begin
      apb(a, 1'h0, 32'h0000_0000, 1'h0);
      chk(rd, exp);
    end
  endtask
  task core_wr(input logic [3:0] s, input logic [1:0] z, input logic [31:0] d);
    begin
      ex_wr_sel <= s;
      ex_wr_size <= z;
      ex_wr_data <= d;
      ex_wr_en <= 1'h1;
      @(posedge core_clk);
      ex_wr_en <= 1'h0;
      @(posedge core_clk);
    end
  endtask

  // ==========================================
  // Sequence
  initial begin
    rows[0] = '{`OFS_DATA_REG_0, 32'hFFFF_A5C3, 32'h0000_A5C3, 1'h0};
    rows[1] = '{`OFS_DATA_REG_1, 32'h1111_2222, 32'h0000_2222, 1'h0};
    rows[2] = '{`OFS_DATA_REG_2, 32'h0000_3333, 32'h0000_3333, 1'h0};
    rows[3] = '{`OFS_DATA_REG_3, 32'h0000_4444, 32'h0000_4444, 1'h0};
    rows[4] = '{`OFS_ADDR_INDEX_0, 32'hFFAB_CDEF, 32'h00AB_CDEF, 1'h0};
    rows[5] = '{`OFS_ADDR_INDEX_1, 32'h0012_3456, 32'h0012_3456, 1'h0};
    rows[6] = '{`OFS_STATIC_BASE, 32'h00A0_0000, 32'h00A0_0000, 1'h0};
    rows[7] = '{`OFS_FRAME_BASE, 32'h0000_0FFE, 32'h0000_0FFE, 1'h0};
    rows[8] = '{`OFS_USER_STACK, 32'h0000_1000, 32'h0000_1000, 1'h0};
    rows[9] = '{`OFS_INTR_STACK, 32'h0000_2000, 32'h0000_2000, 1'h0};
    rows[10] = '{`OFS_VECTOR_BASE, 32'h00FF_FF00, 32'h00FF_FF00, 1'h0};
    rows[11] = '{`OFS_PROGRAM_COUNTER, 32'h0012_3456, 32'h0000_0000, 1'h0};
    rows[12] = '{12'h038, 32'h0000_0001, 32'h0000_0000, 1'h1};
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    for (i = 0; i < 13; i = i + 1) begin
      apb(rows[i].a, 1'h1, rows[i].wd, 1'h0);
      chk({31'h0, er}, {31'h0, rows[i].er});
      rdchk(rows[i].a, rows[i].exp);
    end
    chk({8'h00, static_base_out}, 32'h00A0_0000);
    chk({8'h00, frame_base_out}, 32'h0000_0FFE);
    chk({8'h00, vector_base_out}, 32'h00FF_FF00);
    rdchk(`OFS_ACTIVE_STACK, 32'h0000_1000);
    apb(`OFS_FLAG_WORD, 1'h1, 32'h0000_0080, 1'h0);
    rdchk(`OFS_ACTIVE_STACK, 32'h0000_2000);
    chk({8'h00, stack_pointer}, 32'h0000_2000);
    chk({16'h0000, flag_word_out}, 32'h0000_0080);
    apb(`OFS_FLAG_WORD, 1'h1, 32'h0000_0010, 1'h0);
    rdchk(`OFS_DATA_REG_0, 32'h0000_0000);
    apb(`OFS_DATA_REG_0, 1'h1, 32'h0000_BEEF, 1'h0);
    apb(`OFS_FLAG_WORD, 1'h1, 32'h0000_0000, 1'h0);
    rdchk(`OFS_DATA_REG_0, 32'h0000_A5C3);
    chk({8'h00, stack_pointer}, 32'h0000_1000);
    core_wr(`SEL_D0, `SZ_LOW, 32'h0000_0011);
    rdchk(`OFS_DATA_REG_0, 32'h0000_A511);
    core_wr(`SEL_D0, `SZ_HIGH, 32'h0000_0022);
    rdchk(`OFS_DATA_REG_0, 32'h0000_2211);
    core_wr(`SEL_D1, `SZ_LONG, 32'h8765_4321);
    rdchk(`OFS_DATA_REG_1, 32'h0000_4321);
    rdchk(`OFS_DATA_REG_3, 32'h0000_8765);
    ex_rd_sel_a <= `SEL_D1;
    ex_rd_size_a <= `SZ_LONG;
    ex_rd_sel_b <= `SEL_SB;
    repeat (2) @(posedge core_clk);
    chk(ex_rd_data_a, 32'h8765_4321);
    chk(ex_rd_data_b, 32'h00A0_0000);
    ex_rd_sel_a <= `SEL_D0;
    ex_rd_size_a <= `SZ_HIGH;
    repeat (2) @(posedge core_clk);
    chk(ex_rd_data_a, 32'h0000_0022);
    ex_rd_size_a <= `SZ_LOW;
    repeat (2) @(posedge core_clk);
    chk(ex_rd_data_a, 32'h0000_0011);
    apb(`OFS_ACTIVE_STACK, 1'h1, 32'h0000_1004, 1'h0);
    rdchk(`OFS_USER_STACK, 32'h0000_1004);
    ex_wr_sel <= `SEL_A0;
    ex_wr_size <= `SZ_WORD;
    ex_wr_data <= 32'h0055_AA00;
    apb(`OFS_ADDR_INDEX_1, 1'h1, 32'h0000_0002, 1'h1);
    chk({31'h0, er}, 32'h0000_0001);
    rdchk(`OFS_ADDR_INDEX_1, 32'h0012_3456);
    rdchk(`OFS_ADDR_INDEX_0, 32'h0055_AA00);
    run <= 1'h1;
    repeat (5) @(posedge core_clk);
    run <= 1'h0;
    repeat (3) @(posedge core_clk);
    chk({8'h00, program_counter_out}, {8'h00, pc_model});
    chk({8'h00, program_counter_out}, 32'h0000_000A);
    apb(`OFS_FLAG_WORD, 1'h1, 32'h0000_0080, 1'h0);
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    rdchk(`OFS_ADDR_INDEX_0, 32'h0000_0000);
    chk({16'h0000, flag_word_out}, 32'h0000_0000);
    chk({8'h00, program_counter_out}, 32'h0000_0000);
    end_sim;
  end
endmodule
